// >>> verilog/rssc_regs.svh
// Constants for the reset, startup and strap control block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RSSC_REGS_SVH
`define RSSC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define RSSC_OFF_PLL_CTRL     8'h00
`define RSSC_OFF_STATUS       8'h04
`define RSSC_OFF_VECTOR       8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSSC_PLL_MUL_LSB      0
`define RSSC_PLL_MUL_W        6
`define RSSC_PLL_DIV_LSB      8
`define RSSC_PLL_DIV_W        2
`define RSSC_ST_RATIO_LSB     0
`define RSSC_ST_BOOT_LSB      2
`define RSSC_ST_RUN_BIT       4
`define RSSC_ST_LOCK_BIT      5
`define RSSC_ST_RSVD_BIT      6

// ----------------------------------------------------------------
// Strap codes
// ----------------------------------------------------------------
`define RSSC_RATIO_CODE_3     2'h0
`define RSSC_RATIO_CODE_16    2'h1
`define RSSC_RATIO_CODE_8     2'h2
`define RSSC_RATIO_VAL_3      6'h03
`define RSSC_RATIO_VAL_16     6'h10
`define RSSC_RATIO_VAL_8      6'h08

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RSSC_PLL_DIV_RST      2'h0
`define RSSC_RESET_VECTOR     32'h0009_0000
`define RSSC_LOCK_CYCLES      4096
`define RSSC_REF_DIV          4

`endif

// >>> verilog/rssc_pkg.sv
// Types for the reset, startup and strap control block.
// Assumes rssc_regs.svh supplies all numbers.
package rssc_pkg;

	// Startup sequence states
	typedef enum logic [1:0] {
		RSSC_ST_RESET = 2'b00,
		RSSC_ST_LOCK  = 2'b01,
		RSSC_ST_RUN   = 2'b10
	} rssc_state_t;

	// Boot source decoded from its strap
	typedef enum logic [1:0] {
		RSSC_BOOT_SPI_SLAVE  = 2'b00,
		RSSC_BOOT_SPI_MASTER = 2'b01,
		RSSC_BOOT_PARALLEL   = 2'b10,
		RSSC_BOOT_RESERVED   = 2'b11
	} rssc_boot_t;

endpackage

// >>> verilog/rssc_ref_tick.sv
// Divider giving a one-cycle pulse per reference clock period.
// Assumes one core clock; the reference rate is a fixed fraction of it.
`timescale 1ns/1ps
`include "rssc_regs.svh"

module rssc_ref_tick #(
	parameter int DIV = `RSSC_REF_DIV
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	output logic      o_tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} rssc_tick_t;

	rssc_tick_t st;
	rssc_tick_t next_st;

	// Count down, pulse at wrap
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!i_run) begin
			next_st.cnt = 16'(DIV - 1);
		end else if (st.cnt == 16'h0000) begin
			next_st.cnt = 16'(DIV - 1);
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt - 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_tick = st.tick;
endmodule

// >>> verilog/rssc_lock_timer.sv
// Counter of reference clock ticks for the PLL lock interval.
// Assumes ticks are one-cycle pulses; clear restarts it.
`timescale 1ns/1ps
`include "rssc_regs.svh"

module rssc_lock_timer #(
	parameter int LOCK_CYCLES = `RSSC_LOCK_CYCLES
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_clear,
	input  wire logic i_tick,
	output logic      o_done
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        done;
	} rssc_lock_t;

	rssc_lock_t st;
	rssc_lock_t next_st;

	// Saturating count; done stays until cleared
	always_comb begin
		next_st = st;
		if (i_clear) begin
			next_st = '0;
		end else if (i_tick && !st.done) begin
			if (st.cnt == 16'(LOCK_CYCLES - 1)) begin
				next_st.done = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_done = st.done;
endmodule

// >>> verilog/rssc_top.sv
// Startup control: strap capture, PLL lock wait, core release, reset out.
// Assumes straps, reset and bus signals synchronous to i_core_clk.
`timescale 1ns/1ps
`include "rssc_regs.svh"

// Notes on behaviour
// - The captured clock strap sets the startup ratio: 00 is 3, 01 is 16, 10 is 8, 11 is reserved.
// - After the core leaves reset software may rewrite the PLL multiplier and divider at any time.
// - The internal core reset is driven out on a dedicated output pin.
// - After reset release the block waits 4096 reference clock cycles for PLL lock.
// - When the lock interval ends the core starts fetching at the fixed reset vector.
// - The boot strap selects SPI slave, SPI master, parallel EPROM boot or reserved.
// - In SPI master boot the serial clock and master data out are driven during reset.
module rssc_top #(
	parameter int LOCK_CYCLES = `RSSC_LOCK_CYCLES,
	parameter int REF_DIV     = `RSSC_REF_DIV
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic [1:0]  i_core_ratio_strap,
	input  wire logic [1:0]  i_boot_source_strap,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	output logic             o_core_reset_output_n,
	output logic             o_core_run,
	output logic [31:0]      o_fetch_addr,
	output logic             o_fetch_start,
	output logic [5:0]       o_pll_mul,
	output logic [1:0]       o_pll_div,
	output logic             o_pll_update,
	output logic [1:0]       o_boot_mode,
	output logic             o_strap_reserved,
	output logic             o_serial_shift_clock_pin_o,
	output logic             o_serial_shift_clock_pin_oe,
	output logic             o_master_data_pin_o,
	output logic             o_master_data_pin_oe
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rssc_pkg::rssc_state_t fsm;
		logic                  caught;
		logic [1:0]            ratio_code;
		logic [1:0]            boot_code;
		logic [5:0]            pll_mul;
		logic [1:0]            pll_div;
		logic                  pll_update;
		logic                  fetch_start;
		logic [31:0]           rdata;
	} rssc_top_st_t;

	rssc_top_st_t st;
	rssc_top_st_t next_st;

	logic ref_tick;
	logic lock_done;
	logic lock_clear;
	logic spi_master;

	// ----------------------------------------------------------------
	// Reference clock tick and lock timer
	// ----------------------------------------------------------------
	// Ticks only run while locking, so the interval starts cleanly
	rssc_ref_tick #(
		.DIV (REF_DIV)
	) u_tick (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_run      (st.fsm == rssc_pkg::RSSC_ST_LOCK),
		.o_tick     (ref_tick)
	);

	// Cleared only while in reset, so the lock flag stays readable once running
	assign lock_clear = (st.fsm == rssc_pkg::RSSC_ST_RESET);

	rssc_lock_timer #(
		.LOCK_CYCLES (LOCK_CYCLES)
	) u_lock (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_clear    (lock_clear),
		.i_tick     (ref_tick),
		.o_done     (lock_done)
	);

	// ----------------------------------------------------------------
	// Strap decode
	// ----------------------------------------------------------------
	// Startup multiplier from captured ratio strap
	function automatic logic [5:0] ratio_of(input logic [1:0] code);
		logic [5:0] v;
		v = `RSSC_RATIO_VAL_3;
		unique case (code)
			`RSSC_RATIO_CODE_3:  v = `RSSC_RATIO_VAL_3;
			`RSSC_RATIO_CODE_16: v = `RSSC_RATIO_VAL_16;
			`RSSC_RATIO_CODE_8:  v = `RSSC_RATIO_VAL_8;
			default:             v = `RSSC_RATIO_VAL_3;  // Reserved: safest slow ratio
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Sequencer and register file
	// ----------------------------------------------------------------
	// Straps are sampled in the first cycle out of reset, not under reset
	always_comb begin
		next_st = st;
		next_st.pll_update = 1'b0;
		next_st.fetch_start = 1'b0;
		next_st.rdata = 32'h0000_0000;
		unique case (st.fsm)
			rssc_pkg::RSSC_ST_RESET: begin
				next_st.ratio_code = i_core_ratio_strap;
				next_st.boot_code = i_boot_source_strap;
				next_st.pll_mul = ratio_of(i_core_ratio_strap);
				next_st.pll_div = `RSSC_PLL_DIV_RST;
				next_st.pll_update = 1'b1;
				next_st.caught = 1'b1;
				next_st.fsm = rssc_pkg::RSSC_ST_LOCK;
			end
			rssc_pkg::RSSC_ST_LOCK: begin
				if (lock_done) begin
					next_st.fsm = rssc_pkg::RSSC_ST_RUN;
					next_st.fetch_start = 1'b1;
				end
			end
			rssc_pkg::RSSC_ST_RUN: begin
				// PLL settings are only writable once running
				if (i_wr && i_addr == `RSSC_OFF_PLL_CTRL) begin
					next_st.pll_mul = i_wdata[`RSSC_PLL_MUL_LSB +: `RSSC_PLL_MUL_W];
					next_st.pll_div = i_wdata[`RSSC_PLL_DIV_LSB +: `RSSC_PLL_DIV_W];
					next_st.pll_update = 1'b1;
				end
			end
			default: begin
				next_st.fsm = rssc_pkg::RSSC_ST_RESET;
			end
		endcase
		// Reads: unmapped addresses answer zero
		if (i_rd) begin
			unique case (i_addr)
				`RSSC_OFF_PLL_CTRL: begin
					next_st.rdata[`RSSC_PLL_MUL_LSB +: `RSSC_PLL_MUL_W] = st.pll_mul;
					next_st.rdata[`RSSC_PLL_DIV_LSB +: `RSSC_PLL_DIV_W] = st.pll_div;
				end
				`RSSC_OFF_STATUS: begin
					next_st.rdata[`RSSC_ST_RATIO_LSB +: 2] = st.ratio_code;
					next_st.rdata[`RSSC_ST_BOOT_LSB +: 2] = st.boot_code;
					next_st.rdata[`RSSC_ST_RUN_BIT] = (st.fsm == rssc_pkg::RSSC_ST_RUN);
					next_st.rdata[`RSSC_ST_LOCK_BIT] = lock_done;
					next_st.rdata[`RSSC_ST_RSVD_BIT] = o_strap_reserved;
				end
				`RSSC_OFF_VECTOR: begin
					next_st.rdata = `RSSC_RESET_VECTOR;
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Core reset follows the sequencer so devices leave reset with the core
	assign o_core_reset_output_n = (st.fsm == rssc_pkg::RSSC_ST_RUN);
	assign o_core_run = (st.fsm == rssc_pkg::RSSC_ST_RUN);
	assign o_fetch_addr = `RSSC_RESET_VECTOR;
	assign o_fetch_start = st.fetch_start;
	assign o_pll_mul = st.pll_mul;
	assign o_pll_div = st.pll_div;
	assign o_pll_update = st.pll_update;
	assign o_rdata = st.rdata;
	assign o_boot_mode = st.boot_code;
	assign o_strap_reserved = st.caught && ((st.ratio_code == 2'h3) || (st.boot_code == 2'h3));

	// Master boot: live strap during reset, captured strap afterwards
	assign spi_master = st.caught ? (st.boot_code == rssc_pkg::RSSC_BOOT_SPI_MASTER)
	                              : (i_boot_source_strap == rssc_pkg::RSSC_BOOT_SPI_MASTER);
	// Idle levels: clock high, data low; held only until boot logic takes over
	assign o_serial_shift_clock_pin_o = 1'b1;
	assign o_serial_shift_clock_pin_oe = spi_master && !o_core_run;
	assign o_master_data_pin_o = 1'b0;
	assign o_master_data_pin_oe = spi_master && !o_core_run;
endmodule

// >>> verif/rssc_checker.sv
// Checker for the startup block, bound to the top module ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "rssc_regs.svh"
module rssc_checker #(
	parameter int LOCK_CYCLES = `RSSC_LOCK_CYCLES,
	parameter int REF_DIV     = `RSSC_REF_DIV
) (
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic [1:0]  i_core_ratio_strap,
	input wire logic [1:0]  i_boot_source_strap,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        o_core_reset_output_n,
	input wire logic        o_core_run,
	input wire logic [31:0] o_fetch_addr,
	input wire logic        o_fetch_start,
	input wire logic [5:0]  o_pll_mul,
	input wire logic [1:0]  o_pll_div,
	input wire logic        o_pll_update,
	input wire logic [1:0]  o_boot_mode,
	input wire logic        o_strap_reserved,
	input wire logic        o_serial_shift_clock_pin_o,
	input wire logic        o_serial_shift_clock_pin_oe,
	input wire logic        o_master_data_pin_o,
	input wire logic        o_master_data_pin_oe
);
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	int          wait_cnt;
	logic [31:0] last_wdata;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// Cycles outside run since release; slack allows for capture edge
	always_ff @(posedge i_core_clk) begin
		wait_cnt   <= (!i_rst_n || o_core_run) ? 0 : wait_cnt + 1;
		last_wdata <= i_wdata;
	end
	function automatic logic [5:0] ratio_of(input logic [1:0] c);
		return (c == 2'h1) ? 6'h10 : ((c == 2'h2) ? 6'h08 : 6'h03);
	endfunction
	property p_run_tie; o_core_reset_output_n == o_core_run; endproperty
	a_run_tie: assert property (p_run_tie) else $error("reset out differs from run");
	property p_lock_wait;
		$rose(o_core_run) |-> wait_cnt >= LOCK_CYCLES * REF_DIV && wait_cnt <= LOCK_CYCLES * REF_DIV + 4;
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("lock wait length wrong");
	property p_fetch; $rose(o_core_run) |-> o_fetch_start && o_fetch_addr == `RSSC_RESET_VECTOR; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch start missing");
	property p_ratio;
		$rose(i_rst_n) |=> o_pll_mul == ratio_of($past(i_core_ratio_strap)) && o_pll_div == 2'h0 && o_pll_update;
	endproperty
	a_ratio: assert property (p_ratio) else $error("startup ratio wrong");
	property p_boot;
		$rose(i_rst_n) |=> o_boot_mode == $past(i_boot_source_strap)
			&& o_strap_reserved == (&$past(i_core_ratio_strap) || &$past(i_boot_source_strap));
	endproperty
	a_boot: assert property (p_boot) else $error("boot mode wrong");
	property p_hold; $past(i_rst_n) && $past(i_rst_n, 2) |-> $stable(o_boot_mode) && $stable(o_strap_reserved); endproperty
	a_hold: assert property (p_hold) else $error("captured strap moved");
	property p_pll_wr;
		o_core_run && i_wr && i_addr == 8'h00 |=> o_pll_mul == last_wdata[5:0] && o_pll_div == last_wdata[9:8];
	endproperty
	a_pll_wr: assert property (p_pll_wr) else $error("pll write lost");
	property p_no_wr; !o_core_run && i_wr && $past(i_rst_n) |=> $stable(o_pll_mul) && $stable(o_pll_div); endproperty
	a_no_wr: assert property (p_no_wr) else $error("pll written before run");
	property p_spi;
		!o_core_run && o_boot_mode == 2'h1 |-> o_serial_shift_clock_pin_oe && o_master_data_pin_oe
			&& o_serial_shift_clock_pin_o && !o_master_data_pin_o;
	endproperty
	a_spi: assert property (p_spi) else $error("serial pins not driven");
	c_run: cover property ($rose(o_core_run));
	c_wr: cover property (o_core_run && i_wr);
	c_spi: cover property (!o_core_run && o_boot_mode == 2'h1);
endmodule
bind rssc_top rssc_checker #(
	.LOCK_CYCLES (LOCK_CYCLES),
	.REF_DIV     (REF_DIV)
) i_chk (
	.i_core_clk                  (i_core_clk),
	.i_rst_n                     (i_rst_n),
	.i_core_ratio_strap          (i_core_ratio_strap),
	.i_boot_source_strap         (i_boot_source_strap),
	.i_addr                      (i_addr),
	.i_wdata                     (i_wdata),
	.i_wr                        (i_wr),
	.i_rd                        (i_rd),
	.o_rdata                     (o_rdata),
	.o_core_reset_output_n       (o_core_reset_output_n),
	.o_core_run                  (o_core_run),
	.o_fetch_addr                (o_fetch_addr),
	.o_fetch_start               (o_fetch_start),
	.o_pll_mul                   (o_pll_mul),
	.o_pll_div                   (o_pll_div),
	.o_pll_update                (o_pll_update),
	.o_boot_mode                 (o_boot_mode),
	.o_strap_reserved            (o_strap_reserved),
	.o_serial_shift_clock_pin_o  (o_serial_shift_clock_pin_o),
	.o_serial_shift_clock_pin_oe (o_serial_shift_clock_pin_oe),
	.o_master_data_pin_o         (o_master_data_pin_o),
	.o_master_data_pin_oe        (o_master_data_pin_oe)
);

// >>> verif/rssc_board.sv
// Board reset source and strap pins.
// Assumes the bench requests each reset with a one-cycle start pulse.
`timescale 1ns/1ps
module rssc_board (
	input  wire logic       i_core_clk,
	input  wire logic       i_start,
	input  wire logic [1:0] i_ratio,
	input  wire logic [1:0] i_boot,
	output logic            o_rst_n,
	output logic [1:0]      o_ratio,
	output logic [1:0]      o_boot
);
	int   cnt     = 1;
	logic rst_n_q = 1'b0;
	// Test clock and test reset held low from power-up; the block has no test port
	logic test_clk   = 1'b0;
	logic test_rst_n = 1'b0;
	// Reset low from power-up; straps wander after capture to expose latching
	always @(posedge i_core_clk) begin
		cnt     <= i_start ? 1 : ((cnt < 40) ? cnt + 1 : cnt);
		rst_n_q <= !(i_start || cnt < 10);
		if (cnt >= 12 && cnt < 40 && !i_start) begin
			o_ratio <= ~o_ratio;
			o_boot  <= ~o_boot;
		end else begin
			o_ratio <= i_ratio;
			o_boot  <= i_boot;
		end
	end
	// One driver for the reset pin, low from time zero
	assign o_rst_n = rst_n_q;
endmodule

// >>> verif/reset_startup_strap_control_bench.sv
// Bench for the startup block: every strap pair, bus access, pll writes.
// Assumes the board model drives reset and straps.
`timescale 1ns/1ps
`include "rssc_regs.svh"
module reset_startup_strap_control_bench;
	logic        i_core_clk, i_rst_n, i_wr = 1'b0, i_rd = 1'b0, start = 1'b0;
	logic [1:0]  i_core_ratio_strap, i_boot_source_strap, o_pll_div, o_boot_mode, w_r = 2'h0, w_b = 2'h0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000, o_rdata, o_fetch_addr, pll;
	logic [5:0]  o_pll_mul;
	logic        o_core_reset_output_n, o_core_run, o_fetch_start, o_pll_update, o_strap_reserved;
	logic        o_serial_shift_clock_pin_o, o_serial_shift_clock_pin_oe, o_master_data_pin_o, o_master_data_pin_oe;
	logic [15:0] seed = 16'h0028;
	int          num_errors = 0, num_checks = 0, cycles = 0;
	rssc_top #(.LOCK_CYCLES(4), .REF_DIV(2)) i_dut (
		.i_core_clk                  (i_core_clk),
		.i_rst_n                     (i_rst_n),
		.i_core_ratio_strap          (i_core_ratio_strap),
		.i_boot_source_strap         (i_boot_source_strap),
		.i_addr                      (i_addr),
		.i_wdata                     (i_wdata),
		.i_wr                        (i_wr),
		.i_rd                        (i_rd),
		.o_rdata                     (o_rdata),
		.o_core_reset_output_n       (o_core_reset_output_n),
		.o_core_run                  (o_core_run),
		.o_fetch_addr                (o_fetch_addr),
		.o_fetch_start               (o_fetch_start),
		.o_pll_mul                   (o_pll_mul),
		.o_pll_div                   (o_pll_div),
		.o_pll_update                (o_pll_update),
		.o_boot_mode                 (o_boot_mode),
		.o_strap_reserved            (o_strap_reserved),
		.o_serial_shift_clock_pin_o  (o_serial_shift_clock_pin_o),
		.o_serial_shift_clock_pin_oe (o_serial_shift_clock_pin_oe),
		.o_master_data_pin_o         (o_master_data_pin_o),
		.o_master_data_pin_oe        (o_master_data_pin_oe)
	);
	rssc_board i_board (.i_core_clk(i_core_clk), .i_start(start), .i_ratio(w_r), .i_boot(w_b),
		.o_rst_n(i_rst_n), .o_ratio(i_core_ratio_strap), .o_boot(i_boot_source_strap));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// Hang guard, far above sixteen startups
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	function automatic int ratio_of(input int c);
		return (c == 1) ? 16 : ((c == 2) ? 8 : 3);
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(what, exp, o_rdata);
	endtask
	// One reset and startup with given straps, then bus traffic
	task automatic boot(input int r, input int b);
		int n;
		@(posedge i_core_clk);
		w_r <= 2'(r);
		w_b <= 2'(b);
		@(posedge i_core_clk);
		start <= 1'b1;
		@(posedge i_core_clk);
		start <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		#1 chk("reset out low", 0, o_core_reset_output_n);
		chk("clock pin oe", b == 1, o_serial_shift_clock_pin_oe);
		chk("data pin oe", b == 1, o_master_data_pin_oe);
		for (n = 0; n < 50 && i_rst_n !== 1'b1; n++) @(posedge i_core_clk) #1;
		wr(8'h00, 32'h0000_0305);
		for (n = 0; n < 100 && o_core_run !== 1'b1; n++) @(posedge i_core_clk) #1;
		chk("fetch start", 1, o_fetch_start);
		chk("fetch addr", `RSSC_RESET_VECTOR, o_fetch_addr);
		chk("reset out high", 1, o_core_reset_output_n);
		chk("startup ratio", ratio_of(r), o_pll_mul);
		chk("boot mode", b, o_boot_mode);
		chk("reserved", r == 3 || b == 3, o_strap_reserved);
		chk("clock pin oe run", 0, o_serial_shift_clock_pin_oe);
		chk("data pin oe run", 0, o_master_data_pin_oe);
		rd(8'h04, r | (b << 2) | 32'h0000_0030 | ((r == 3 || b == 3) << 6), "status");
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		pll = {22'h0, seed[9:8], 2'h0, seed[5:0]};
		wr(8'h00, pll);
		chk("pll mul", seed[5:0], o_pll_mul);
		chk("pll div", seed[9:8], o_pll_div);
		chk("pll update", 1, o_pll_update);
		rd(8'h00, pll, "pll readback");
		rd(8'h08, `RSSC_RESET_VECTOR, "vector");
		rd(8'h0c, 0, "unmapped");
		$display("test ratio %0d boot %0d done", r, b);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 16; i++) boot(i / 4, i % 4);
		end_of_test();
	end
endmodule
